/* File: hdl/pdr_macrocell.sv */
// Register layer of a programmable logic device with APB fuse access
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "pdr_defines.svh"

module pdr_macrocell (
    // APB clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`PDR_AW-1:0]    paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Array terms per register, shared preset term and dedicated clock pin
    input  wire pdr_pkg::pdr_terms_t   terms,
    input  wire logic                  sync_preset,
    input  wire logic                  clk_pin,
    // Output enable terms, per cell
    input  wire logic [`PDR_NCELL-1:0] oe_terms,
    // Preload control pins
    input  wire logic                  preload_hv,
    input  wire logic                  preload_sel,
    // Bidirectional I/O pins
    input  wire logic [`PDR_NCELL-1:0] io_in,
    output logic      [`PDR_NCELL-1:0] io_out,
    output logic      [`PDR_NCELL-1:0] io_oe,
    // Paths into the array
    output logic      [`PDR_NREG-1:0]  reg_feedback,
    output logic      [`PDR_NCELL-1:0] pin_feedback
);

    typedef struct packed {
        logic [`PDR_NREG-1:0]    q;
        logic [`PDR_NREG-1:0]    ttype;
        logic [`PDR_NREG-1:0]    clksel;
        logic [`PDR_NCELL-1:0]   pol;
        logic                    secure;
        logic [`PDR_NREG-1:0]    clk_term_d;
        logic                    clk_pin_d;
        pdr_pkg::pdr_pins_t      pins;
        logic [`PDR_NREG-1:0]    fb;
        logic [`PDR_NCELL-1:0]   pin_fb;
        pdr_pkg::pdr_bus_state_t bus;
        pdr_pkg::pdr_apb_rsp_t   rsp;
    } pdr_state_t;

    pdr_state_t st;
    pdr_state_t next_st;

    pdr_pkg::pdr_apb_req_t req;
    pdr_pkg::pdr_terms_t   s_terms;

    logic                    s_preset;
    logic                    s_clk_pin;
    logic [`PDR_NCELL-1:0]   s_oe;
    logic                    s_hv;
    logic                    s_sel;
    logic [`PDR_NCELL-1:0]   s_io;
    logic [`PDR_SYNC_W-1:0]  sync_out;

    // All pin-side inputs cross into pclk together
    pdr_sync #(
        .W(`PDR_SYNC_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .async_in({terms, sync_preset, clk_pin, oe_terms, preload_hv, preload_sel, io_in}),
        .sync_out(sync_out)
    );

    assign {s_terms, s_preset, s_clk_pin, s_oe, s_hv, s_sel, s_io} = sync_out;

    assign req.psel    = psel;
    assign req.penable = penable;
    assign req.pwrite  = pwrite;
    assign req.paddr   = paddr;
    assign req.pwdata  = pwdata;

    // Known register offset check, shared by write and error paths
    function automatic logic addr_hit(input logic [`PDR_AW-1:0] a);
        case (a)
            `PDR_OFF_TTYPE, `PDR_OFF_CLKSEL, `PDR_OFF_POL,
            `PDR_OFF_SECURE, `PDR_OFF_STATE, `PDR_OFF_PINS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    // Fuse readback; masked once the security bit is set
    function automatic logic [31:0] fuse_read(input logic [31:0] v, input logic sec);
        fuse_read = sec ? `PDR_FUSE_MASKED : v;
    endfunction

    function automatic logic [31:0] read_mux(input pdr_state_t s, input logic [`PDR_AW-1:0] a,
                                             input logic [`PDR_NCELL-1:0] pins_now);
        read_mux = 32'h00000000;
        case (a)
            `PDR_OFF_TTYPE:  read_mux = fuse_read({12'h000, s.ttype}, s.secure);
            `PDR_OFF_CLKSEL: read_mux = fuse_read({12'h000, s.clksel}, s.secure);
            `PDR_OFF_POL:    read_mux = fuse_read({22'h0, s.pol}, s.secure);
            `PDR_OFF_SECURE: read_mux = {31'h0, s.secure};
            `PDR_OFF_STATE:  read_mux = {12'h000, s.q};
            `PDR_OFF_PINS:   read_mux = {22'h0, pins_now};
            default:         read_mux = 32'h00000000;
        endcase
    endfunction

    logic [`PDR_NREG-1:0] clk_ev;
    logic                 wr_go;
    integer               i;

    always_comb begin
        next_st = st;
        clk_ev  = '0;
        wr_go   = 1'b0;

        // Clock source per flip-flop: own term edge or pin edge
        next_st.clk_term_d = s_terms.clk;
        next_st.clk_pin_d  = s_clk_pin;
        for (i = 0; i < `PDR_NREG; i = i + 1) begin
            if (st.clksel[i]) begin
                clk_ev[i] = s_clk_pin & ~st.clk_pin_d;
            end else begin
                clk_ev[i] = s_terms.clk[i] & ~st.clk_term_d[i];
            end
        end

        for (i = 0; i < `PDR_NREG; i = i + 1) begin
            if (s_terms.rst[i]) begin
                // Reset term overrides any clock in the same cycle
                next_st.q[i] = 1'b0;
            end else if (clk_ev[i]) begin
                if (s_hv) begin
                    // Preload writes only the register chosen by select
                    if (s_sel == i[0]) begin
                        next_st.q[i] = s_io[i/2];
                    end
                end else if (s_preset) begin
                    next_st.q[i] = 1'b1;
                end else if (st.ttype[i]) begin
                    next_st.q[i] = st.q[i] ^ s_terms.sum[i];
                end else begin
                    next_st.q[i] = s_terms.sum[i];
                end
            end
        end

        // Register 0 of each cell drives the pin through its polarity
        for (i = 0; i < `PDR_NCELL; i = i + 1) begin
            next_st.pins.out[i] = next_st.q[2*i] ^ st.pol[i];
        end
        next_st.pins.oe = s_oe;
        next_st.fb      = next_st.q;
        next_st.pin_fb  = s_io;

        // APB: answer one cycle into the access phase
        next_st.rsp.pready  = 1'b0;
        next_st.rsp.pslverr = 1'b0;
        case (st.bus)
            pdr_pkg::PDR_BUS_IDLE: begin
                if (req.psel && req.penable) begin
                    next_st.bus         = pdr_pkg::PDR_BUS_ANS;
                    next_st.rsp.pready  = 1'b1;
                    next_st.rsp.pslverr = ~addr_hit(req.paddr);
                    next_st.rsp.prdata  = req.pwrite ? 32'h00000000 : read_mux(st, req.paddr, s_io);
                end
            end
            pdr_pkg::PDR_BUS_ANS: begin
                next_st.bus = pdr_pkg::PDR_BUS_IDLE;
                wr_go       = req.psel & req.penable & req.pwrite & addr_hit(req.paddr);
            end
            default: begin
                next_st.bus = pdr_pkg::PDR_BUS_IDLE;
            end
        endcase

        // Fuse writes land at the edge that completes the transfer
        if (wr_go) begin
            case (req.paddr)
                `PDR_OFF_TTYPE:  next_st.ttype  = req.pwdata[`PDR_NREG-1:0];
                `PDR_OFF_CLKSEL: next_st.clksel = req.pwdata[`PDR_NREG-1:0];
                `PDR_OFF_POL:    next_st.pol    = req.pwdata[`PDR_NCELL-1:0];
                // Security is a fuse: once set only a full reset clears it
                `PDR_OFF_SECURE: next_st.secure = st.secure | req.pwdata[0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.ttype    <= `PDR_RST_TTYPE;
            st.clksel   <= `PDR_RST_CLKSEL;
            st.pol      <= `PDR_RST_POL;
            st.bus      <= pdr_pkg::PDR_BUS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign pready       = st.rsp.pready;
    assign prdata       = st.rsp.prdata;
    assign pslverr      = st.rsp.pslverr;
    assign io_out       = st.pins.out;
    assign io_oe        = st.pins.oe;
    assign reg_feedback = st.fb;
    assign pin_feedback = st.pin_fb;

endmodule // pdr_macrocell

/* File: hdl/pdr_defines.svh */
// Constants for the dual register macrocell layer
`ifndef PDR_DEFINES_SVH
`define PDR_DEFINES_SVH

`define PDR_NREG        20
`define PDR_NCELL       10
`define PDR_SYNC_W      84

`define PDR_AW          8
`define PDR_OFF_TTYPE   8'h00
`define PDR_OFF_CLKSEL  8'h04
`define PDR_OFF_POL     8'h08
`define PDR_OFF_SECURE  8'h0C
`define PDR_OFF_STATE   8'h10
`define PDR_OFF_PINS    8'h14

`define PDR_RST_TTYPE   20'h00000
`define PDR_RST_CLKSEL  20'h00000
`define PDR_RST_POL     10'h000
`define PDR_FUSE_MASKED 32'hFFFFFFFF

`endif

/* File: hdl/pdr_pkg.sv */
// Types shared by the dual register macrocell layer
`include "pdr_defines.svh"

package pdr_pkg;

    typedef struct packed {
        logic [`PDR_NREG-1:0] sum;
        logic [`PDR_NREG-1:0] clk;
        logic [`PDR_NREG-1:0] rst;
    } pdr_terms_t;

    typedef struct packed {
        logic                psel;
        logic                penable;
        logic                pwrite;
        logic [`PDR_AW-1:0]  paddr;
        logic [31:0]         pwdata;
    } pdr_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } pdr_apb_rsp_t;

    typedef struct packed {
        logic [`PDR_NCELL-1:0] out;
        logic [`PDR_NCELL-1:0] oe;
    } pdr_pins_t;

    typedef enum logic [1:0] {
        PDR_BUS_IDLE = 2'b01,
        PDR_BUS_ANS  = 2'b10
    } pdr_bus_state_t;

endpackage

/* File: hdl/pdr_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`include "pdr_defines.svh"

module pdr_sync #(
    parameter int W = `PDR_SYNC_W
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pdr_sync_state_t;

    pdr_sync_state_t st;
    pdr_sync_state_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.s2;

endmodule // pdr_sync

/* File: test/pdr_props.sv */
// Port checker for the macrocell layer
`timescale 1ns/1ps
module pdr_props (
    // Clock and bus
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         prdata,
    // Cell side
    input wire pdr_pkg::pdr_terms_t terms,
    input wire logic [9:0]          oe_terms,
    input wire logic [9:0]          io_in,
    input wire logic [9:0]          io_oe,
    input wire logic [9:0]          io_out,
    input wire logic [19:0]         reg_feedback,
    input wire logic [9:0]          pin_feedback
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] age;
    // Pin paths hold reset values for a few edges after release
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) age <= 3'h0;
        else if (age != 3'h4) age <= age + 3'h1;
    bus_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    bad_addr_a: assert property (pready && (paddr > 8'h14 || paddr[1:0] != 2'b00) |-> pslverr && prdata == 32'h0)
        else $error("no refusal");
    good_addr_a: assert property (pready && paddr[1:0] == 2'b00 && paddr < 8'h18 |-> !pslverr)
        else $error("false refusal");
    reset_low_a: assert property ($rose(presetn) |-> reg_feedback == 20'h0 && io_out == 10'h0)
        else $error("not cleared");
    term_clear_a: assert property ((terms.rst & $past(terms.rst) & $past(terms.rst, 2)
        & $past(terms.rst, 3) & reg_feedback) == 20'h0) else $error("reset term ignored");
    oe_path_a: assert property (age == 3'h4 |-> io_oe == $past(oe_terms, 3)) else $error("oe path");
    pin_path_a: assert property (age == 3'h4 |-> pin_feedback == $past(io_in, 3)) else $error("pin path");
    cover property (pready && pslverr);
    cover property (terms.rst != 20'h0 && reg_feedback == 20'h0);
    cover property ($changed(io_out));
endmodule // pdr_props
bind pdr_macrocell pdr_props u_props (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pready      (pready),
    .pslverr     (pslverr),
    .paddr       (paddr),
    .prdata      (prdata),
    .terms       (terms),
    .oe_terms    (oe_terms),
    .io_in       (io_in),
    .io_oe       (io_oe),
    .io_out      (io_out),
    .reg_feedback(reg_feedback),
    .pin_feedback(pin_feedback)
);

/* File: test/pdr_board.sv */
// Board model driving the dedicated clock pin
`timescale 1ns/1ps
module pdr_board (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pulse request and pin
    input wire logic fire,
    input wire logic slow,
    output logic     clk_pin,
    output logic     busy
);
    logic [3:0] cnt;
    // Pin stays low 4 cycles after each pulse so feedback setup is met
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) cnt <= 4'h0;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
        else if (fire) cnt <= slow ? 4'hC : 4'h8;
    assign clk_pin = cnt inside {[4'h5:4'h8]};
    assign busy = cnt != 4'h0;
endmodule // pdr_board

/* File: test/test_pdr_macrocell.sv */
// Self-checking bench for the macrocell layer
`timescale 1ns/1ps
`include "pdr_defines.svh"
module test_pdr_macrocell;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic                sync_preset, clk_pin, preload_hv, preload_sel, fire, slow, busy;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rdat;
    logic [9:0]          oe_terms, io_in, io_out, io_oe, pin_feedback, pol;
    logic [19:0]         reg_feedback, q, tt;
    pdr_pkg::pdr_terms_t terms;
    int                  n_fail = 0;
    int                  n_checks = 0;
    pdr_macrocell dut (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .pready      (pready),
        .prdata      (prdata),
        .pslverr     (pslverr),
        .terms       (terms),
        .sync_preset (sync_preset),
        .clk_pin     (clk_pin),
        .oe_terms    (oe_terms),
        .preload_hv  (preload_hv),
        .preload_sel (preload_sel),
        .io_in       (io_in),
        .io_out      (io_out),
        .io_oe       (io_oe),
        .reg_feedback(reg_feedback),
        .pin_feedback(pin_feedback)
    );
    pdr_board board (.pclk(pclk), .presetn(presetn), .fire(fire), .slow(slow), .clk_pin(clk_pin), .busy(busy));
    always #12.5 pclk = ~pclk;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hang;
        n_fail++;
        wrap_up();
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [9:0] evens(input logic [19:0] v);
        for (int c = 0; c < 10; c++) evens[c] = v[2*c];
    endfunction
    // Sum held at F0F0F: T bits toggle where sum is true, D bits take sum
    function automatic logic [19:0] step(input logic [19:0] m);
        return (q & ~m) | (m & ((tt & (q ^ 20'hF0F0F)) | (~tt & 20'hF0F0F)));
    endfunction
    task automatic state_chk;
        chk("state", 32'(q), 32'(reg_feedback));
        chk("pins", 32'(evens(q) ^ pol), 32'(io_out));
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
        if (k >= 20) hang();
        {err, rdat} = {pslverr, prdata};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("rdata", exp, rdat);
    endtask
    task automatic pin_clock(input logic s);
        int k;
        repeat (3) @(posedge pclk);
        {slow, fire} <= {s, 1'b1};
        @(posedge pclk);
        fire <= 1'b0;
        @(posedge pclk);
        for (k = 0; k < 30 && busy !== 1'b0; k++) @(posedge pclk);
        if (k >= 30) hang();
    endtask
    task automatic t_regs;
        rd_chk(`PDR_OFF_TTYPE, 32'(`PDR_RST_TTYPE));
        rd_chk(`PDR_OFF_STATE, 32'h0);
        rd_chk(8'h1C, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        chk("oe", 32'(oe_terms), 32'(io_oe));
        oe_terms <= 10'h2AA;
        repeat (4) @(posedge pclk);
        chk("oe", 32'h2AA, 32'(io_oe));
        state_chk();
        $display("test regs done");
    endtask
    task automatic preload(input logic sel, input logic [9:0] pat, input logic s);
        {io_in, preload_sel} <= {pat, sel};
        pin_clock(s);
        for (int c = 0; c < 10; c++) q[2*c+sel] = pat[c];
        state_chk();
        chk("pin in", 32'(pat), 32'(pin_feedback));
        rd_chk(`PDR_OFF_PINS, 32'(pat));
    endtask
    task automatic t_preload;
        pol = 10'h3FF;
        apb(1'b1, `PDR_OFF_CLKSEL, 32'hFFFFF);
        rd_chk(`PDR_OFF_CLKSEL, 32'hFFFFF);
        apb(1'b1, `PDR_OFF_POL, 32'(pol));
        preload_hv <= 1'b1;
        preload(1'b0, 10'h2A5, 1'b0);
        preload(1'b1, 10'h0F3, 1'b1);
        preload_hv <= 1'b0;
        $display("test preload done");
    endtask
    task automatic t_clocks;
        tt = 20'h55555;
        apb(1'b1, `PDR_OFF_TTYPE, 32'(tt));
        apb(1'b1, `PDR_OFF_CLKSEL, 32'hFFC00);
        terms.sum <= 20'hF0F0F;
        for (int n = 0; n < 2; n++) begin
            pin_clock(n[0]);
            q = step(20'hFFC00);
            state_chk();
        end
        terms.clk <= 20'h003FF;
        repeat (4) @(posedge pclk);
        terms.clk <= 20'h0;
        repeat (4) @(posedge pclk);
        q = step(20'h003FF);
        state_chk();
        sync_preset <= 1'b1;
        pin_clock(1'b0);
        sync_preset <= 1'b0;
        q = q | 20'hFFC00;
        state_chk();
        $display("test clocks done");
    endtask
    task automatic t_rst;
        terms.rst <= 20'hC0000;
        repeat (5) @(posedge pclk);
        q = q & 20'h3FFFF;
        state_chk();
        terms.rst <= 20'h0;
        $display("test reset term done");
    endtask
    task automatic t_secure;
        apb(1'b1, `PDR_OFF_SECURE, 32'h1);
        rd_chk(`PDR_OFF_SECURE, 32'h1);
        rd_chk(`PDR_OFF_POL, `PDR_FUSE_MASKED);
        rd_chk(`PDR_OFF_TTYPE, `PDR_FUSE_MASKED);
        apb(1'b1, `PDR_OFF_STATE, 32'h0);
        rd_chk(`PDR_OFF_STATE, 32'(q));
        $display("test security done");
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, sync_preset, preload_hv, preload_sel, fire, slow} = 8'h00;
        {paddr, pwdata, io_in, q, tt, pol} = '0;
        terms = '0;
        oe_terms = 10'h155;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_preload();
        t_clocks();
        t_rst();
        t_secure();
        wrap_up();
    end
endmodule // test_pdr_macrocell
